/* rtl/utmsp_ctrl.sv */
// Test mode selection and suspend/configured status pin logic
`timescale 1ns/1ps
`default_nettype none
`include "utmsp_defines.svh"

module utmsp_ctrl
    import utmsp_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_sw_reset,
    input wire logic i_cs,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [`UTMSP_ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [2:0] i_device_state_field,
    input wire logic [1:0] i_reset_handshake_state,
    output logic [15:0] o_rdata,
    output logic o_suspend_indicator_pin,
    output logic o_suspend_indicator_pin_oe_n,
    output logic o_configured_indicator_pin,
    output logic o_configured_indicator_pin_oe_n,
    output var utmsp_mode_t o_test_mode
);

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic suspend_pin_enable_r, suspend_pin_enable_nxt;
    logic configured_pin_enable_r, configured_pin_enable_nxt;
    logic [2:0] test_select_r, test_select_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic hit;

    // Register reset image, fields picked from it by position
    localparam logic [15:0] ctrl_reset_val = `UTMSP_CTRL_RESET;

    assign hit = i_cs && (i_addr == `UTMSP_OFF_CTRL);

    // Register write and read data
    always_comb
    begin
        suspend_pin_enable_nxt = suspend_pin_enable_r;
        configured_pin_enable_nxt = configured_pin_enable_r;
        test_select_nxt = test_select_r;
        rdata_nxt = 16'h0000;
        if (i_sw_reset)
        begin
            suspend_pin_enable_nxt = ctrl_reset_val[`UTMSP_BIT_SUSP_EN];
            configured_pin_enable_nxt = ctrl_reset_val[`UTMSP_BIT_CONF_EN];
            test_select_nxt = ctrl_reset_val[`UTMSP_TST_HI:`UTMSP_TST_LO];
        end
        else if (hit && i_wr)
        begin
            suspend_pin_enable_nxt = i_wdata[`UTMSP_BIT_SUSP_EN];
            configured_pin_enable_nxt = i_wdata[`UTMSP_BIT_CONF_EN];
            test_select_nxt = i_wdata[`UTMSP_TST_HI:`UTMSP_TST_LO];
        end
        if (hit && i_rd)
        begin
            rdata_nxt[`UTMSP_BIT_SUSP_EN] = suspend_pin_enable_r;
            rdata_nxt[`UTMSP_BIT_CONF_EN] = configured_pin_enable_r;
            rdata_nxt[`UTMSP_TST_HI:`UTMSP_TST_LO] = test_select_r;
        end
    end

    // Register state, cleared by hardware or software reset, never by bus reset
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            suspend_pin_enable_r <= ctrl_reset_val[`UTMSP_BIT_SUSP_EN];
            configured_pin_enable_r <= ctrl_reset_val[`UTMSP_BIT_CONF_EN];
            test_select_r <= `UTMSP_TST_NORMAL;
            rdata_r <= `UTMSP_CTRL_RESET;
        end
        else
        begin
            suspend_pin_enable_r <= suspend_pin_enable_nxt;
            configured_pin_enable_r <= configured_pin_enable_nxt;
            test_select_r <= test_select_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;

    // ------------------------------------------------------------
    // Status pins and test mode
    // ------------------------------------------------------------
    logic susp_pin_nxt, susp_oe_n_nxt, conf_pin_nxt, conf_oe_n_nxt;
    logic susp_pin_r, susp_oe_n_r, conf_pin_r, conf_oe_n_r;
    logic hi_speed;
    utmsp_mode_t mode_nxt, mode_r;

    assign hi_speed = (i_reset_handshake_state == `UTMSP_RESET_HANDSHAKE_STATE_HS);

    // Pin levels and mode decode
    always_comb
    begin
        susp_oe_n_nxt = !suspend_pin_enable_r;
        susp_pin_nxt = !i_device_state_field[`UTMSP_DEVICE_STATE_FIELD_SUSP_BIT];
        conf_oe_n_nxt = !configured_pin_enable_r;
        conf_pin_nxt = !((i_device_state_field & `UTMSP_DEVICE_STATE_FIELD_CONF_MASK) == `UTMSP_DEVICE_STATE_FIELD_CONF_MASK);
        mode_nxt = UTMSP_MODE_NORMAL;
        if (hi_speed)
        begin
            unique case (test_select_r)
                `UTMSP_TST_J: mode_nxt = UTMSP_MODE_J;
                `UTMSP_TST_K: mode_nxt = UTMSP_MODE_K;
                `UTMSP_TST_SE0_NAK: mode_nxt = UTMSP_MODE_SE0_NAK;
                `UTMSP_TST_PACKET: mode_nxt = UTMSP_MODE_PACKET;
                default: mode_nxt = UTMSP_MODE_NORMAL; // Normal and reserved codes
            endcase
        end
    end

    // Output flops
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            susp_pin_r <= 1'b1;
            susp_oe_n_r <= 1'b1;
            conf_pin_r <= 1'b1;
            conf_oe_n_r <= 1'b1;
            mode_r <= UTMSP_MODE_NORMAL;
        end
        else
        begin
            susp_pin_r <= susp_pin_nxt;
            susp_oe_n_r <= susp_oe_n_nxt;
            conf_pin_r <= conf_pin_nxt;
            conf_oe_n_r <= conf_oe_n_nxt;
            mode_r <= mode_nxt;
        end
    end

    assign o_suspend_indicator_pin = susp_pin_r;
    assign o_suspend_indicator_pin_oe_n = susp_oe_n_r;
    assign o_configured_indicator_pin = conf_pin_r;
    assign o_configured_indicator_pin_oe_n = conf_oe_n_r;
    assign o_test_mode = mode_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence susp_req_s;
        suspend_pin_enable_r && i_device_state_field[2];
    endsequence

    susp_low_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        susp_req_s |=> (!o_suspend_indicator_pin && !o_suspend_indicator_pin_oe_n))
        else $error("suspend pin not low");
    susp_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        !suspend_pin_enable_r |=> o_suspend_indicator_pin_oe_n)
        else $error("suspend pin driven while disabled");
    conf_low_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (configured_pin_enable_r && i_device_state_field[1:0] == 2'h3) |=> !o_configured_indicator_pin)
        else $error("configured pin not low");
    conf_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        !configured_pin_enable_r |=> o_configured_indicator_pin_oe_n)
        else $error("configured pin driven while disabled");
    pin_high_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_device_state_field[2] == 1'b0) |=> o_suspend_indicator_pin)
        else $error("suspend pin not high");
    mode_sel_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (hi_speed && test_select_r == 3'h4) |=> (o_test_mode == UTMSP_MODE_PACKET))
        else $error("test packet not selected");
    fs_normal_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_reset_handshake_state != 2'h3) |=> (o_test_mode == UTMSP_MODE_NORMAL))
        else $error("test mode outside Hi-Speed");
    rsvd_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        o_rdata[13:3] == 11'h000)
        else $error("reserved bits nonzero");

    // Back-to-back write then read of the control register
    sequence ctrl_wr_s;
        hit && i_wr && !i_sw_reset;
    endsequence

    sequence ctrl_rd_s;
        hit && i_rd && !i_wr;
    endsequence

    write_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        ctrl_wr_s ##1 ctrl_rd_s |=> (o_rdata[2:0] == $past(i_wdata[2:0], 2)))
        else $error("selector readback wrong");

    // Enabled pins are driven, idle pins sit high
    suspend_indicator_pin_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        suspend_pin_enable_r |=> !o_suspend_indicator_pin_oe_n)
        else $error("suspend pin not driven while enabled");
    configured_indicator_pin_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        configured_pin_enable_r |=> !o_configured_indicator_pin_oe_n)
        else $error("configured pin not driven while enabled");
    conf_high_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_device_state_field[1:0] != 2'h3) |=> o_configured_indicator_pin)
        else $error("configured pin not high");

    // Remaining selector codes at Hi-Speed
    mode_j_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (hi_speed && test_select_r == `UTMSP_TST_J) |=> (o_test_mode == UTMSP_MODE_J))
        else $error("test J not selected");
    mode_k_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (hi_speed && test_select_r == `UTMSP_TST_K) |=> (o_test_mode == UTMSP_MODE_K))
        else $error("test K not selected");
    mode_se0_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (hi_speed && test_select_r == `UTMSP_TST_SE0_NAK) |=> (o_test_mode == UTMSP_MODE_SE0_NAK))
        else $error("test SE0 NAK not selected");
    rsvd_code_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (test_select_r > `UTMSP_TST_PACKET) |=> (o_test_mode == UTMSP_MODE_NORMAL))
        else $error("reserved code applied a test mode");

    // Read data only stands after a read, software reset drops the mode
    rdata_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        !(hit && i_rd) |=> (o_rdata == 16'h0000))
        else $error("read data without a read");
    sw_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_sw_reset |=> ##1 (o_test_mode == UTMSP_MODE_NORMAL))
        else $error("test mode kept after software reset");

endmodule

`default_nettype wire

/* rtl/utmsp_defines.svh */
// Register offsets, field positions, reset values and codes for the test and status pin control block
`ifndef UTMSP_DEFINES_SVH
`define UTMSP_DEFINES_SVH

`define UTMSP_ADDR_W 7
`define UTMSP_OFF_CTRL 7'h06
`define UTMSP_CTRL_RESET 16'h0000
`define UTMSP_BIT_SUSP_EN 15
`define UTMSP_BIT_CONF_EN 14
`define UTMSP_TST_HI 2
`define UTMSP_TST_LO 0
`define UTMSP_DEVICE_STATE_FIELD_SUSP_BIT 2
`define UTMSP_DEVICE_STATE_FIELD_CONF_MASK 3'h3
`define UTMSP_RESET_HANDSHAKE_STATE_HS 2'h3
`define UTMSP_TST_NORMAL 3'h0
`define UTMSP_TST_J 3'h1
`define UTMSP_TST_K 3'h2
`define UTMSP_TST_SE0_NAK 3'h3
`define UTMSP_TST_PACKET 3'h4

`endif

/* rtl/utmsp_pkg.sv */
// Types for the test and status pin control block
package utmsp_pkg;
    typedef enum logic [2:0] {
        UTMSP_MODE_NORMAL,
        UTMSP_MODE_J,
        UTMSP_MODE_K,
        UTMSP_MODE_SE0_NAK,
        UTMSP_MODE_PACKET
    } utmsp_mode_t;
endpackage

/* testbench/utmsp_ctrl_bench.sv */
// Self-checking bench for the test and status pin control block
`timescale 1ns/1ps
`default_nettype none
module utmsp_ctrl_bench import utmsp_pkg::*;;
    logic clk, rst_n, sw_rst, cs, wr, rd, bus_rst, hs, sp, sp_oe_n, cp, cp_oe_n;
    logic [6:0] addr;
    logic [15:0] wdata, rdata;
    logic [2:0] st, dsf;
    logic [1:0] rhs;
    utmsp_mode_t mode;
    int failures, checked, seed, mreg, hs_m;
    utmsp_ctrl dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_sw_reset(sw_rst), .i_cs(cs), .i_wr(wr),
        .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .i_device_state_field(dsf),
        .i_reset_handshake_state(rhs), .o_rdata(rdata), .o_suspend_indicator_pin(sp),
        .o_suspend_indicator_pin_oe_n(sp_oe_n), .o_configured_indicator_pin(cp),
        .o_configured_indicator_pin_oe_n(cp_oe_n), .o_test_mode(mode));
    utmsp_host_model host (.i_ref_clk(clk), .i_reset_n(rst_n), .i_bus_reset(bus_rst), .i_hs_capable(hs),
        .i_state(st), .o_device_state_field(dsf), .o_reset_handshake_state(rhs));
    // 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Register write, model keeps only the stored bits
    task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
        @(negedge clk) {cs, wr, addr, wdata} = {2'b11, a, d};
        @(negedge clk) {cs, wr} = 2'b00;
        if (a == 7'h06)
            mreg = d & 16'hC007;
    endtask
    task automatic rd_reg(input logic [6:0] a);
        @(negedge clk) {cs, rd, addr} = {2'b11, a};
        @(negedge clk) {cs, rd} = 2'b00;
        check(rdata, a == 7'h06 ? mreg[15:0] : 16'h0000);
    endtask
    // Write then read in the very next cycle
    task automatic wr_rd_reg(input logic [6:0] a, input logic [15:0] d);
        @(negedge clk) {cs, wr, rd, addr, wdata} = {3'b110, a, d};
        @(negedge clk) {wr, rd} = 2'b01;
        if (a == 7'h06)
            mreg = d & 16'hC007;
        @(negedge clk) {cs, rd} = 2'b00;
        check(rdata, a == 7'h06 ? mreg[15:0] : 16'h0000);
    endtask
    // Pins and applied mode against the model
    task automatic look;
        repeat (3) @(negedge clk);
        check(sp_oe_n, !mreg[15]);
        check(cp_oe_n, !mreg[14]);
        check(sp | sp_oe_n, mreg[15] ? !st[2] : 1'b1);
        check(cp | cp_oe_n, mreg[14] ? !(st[1] & st[0]) : 1'b1);
        check(mode, (hs_m != 0 && (mreg & 7) <= 4) ? 16'(mreg & 7) : 16'h0000);
    endtask
    initial
    begin
        seed = 32'h1c07;
        {failures, checked, mreg, hs_m} = '0;
        {rst_n, sw_rst, cs, wr, rd, addr, wdata, bus_rst, hs, st} = '0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        rd_reg(7'h06);
        look;
        $display("test 1 done");
        // Random words with reserved bits kept zero, a stray address, back-to-back access
        repeat (8)
        begin
            wr_reg(7'h06, 16'($random(seed)) & 16'hC007);
            rd_reg(7'h06);
            wr_reg(7'h07, 16'($random(seed)));
            rd_reg(7'h07);
            wr_rd_reg(7'h06, 16'($random(seed)) & 16'hC007);
            rd_reg(7'h06);
        end
        $display("test 2 done");
        // Each enable pair against every device state
        for (int e = 0; e < 4; e++)
            for (int s = 0; s < 8; s++)
            begin
                if (s == 0)
                    wr_reg(7'h06, 16'(e << 14));
                @(negedge clk) st = 3'(s);
                look;
            end
        $display("test 3 done");
        // Every selector code while the handshake is open, never at Full-Speed, then at high speed
        for (int h = 0; h < 2; h++)
        begin
            @(negedge clk) {hs, bus_rst} = {h[0], 1'b1};
            @(negedge clk) bus_rst = !h[0];
            repeat (2) @(negedge clk);
            hs_m = h;
            for (int c = 0; c < 8; c++)
            begin
                wr_reg(7'h06, 16'(c));
                look;
            end
            wr_reg(7'h06, 16'h0000);
            @(negedge clk) bus_rst = 1'b0;
            look;
        end
        $display("test 4 done");
        // Software reset clears the register
        wr_reg(7'h06, 16'hC003);
        @(negedge clk) sw_rst = 1'b1;
        @(negedge clk) sw_rst = 1'b0;
        mreg = 0;
        rd_reg(7'h06);
        look;
        $display("test 5 done");
        // Hardware reset in mid-run clears register, pins and mode
        wr_reg(7'h06, 16'hC004);
        @(negedge clk) rst_n = 1'b0;
        @(negedge clk) check(sp_oe_n, 1'b1);
        check(mode, 16'h0000);
        rst_n = 1'b1;
        {mreg, hs_m} = '0;
        rd_reg(7'h06);
        look;
        $display("test 6 done");
        report_and_stop;
    end
    // Watchdog well past the expected run length
    initial
    begin
        #200000;
        failures++;
        report_and_stop;
    end
endmodule
`default_nettype wire

/* testbench/utmsp_host_model.sv */
// Far-side model: host reset handshake and device state source
`timescale 1ns/1ps
`default_nettype none
module utmsp_host_model (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_bus_reset,
    input wire logic i_hs_capable,
    input wire logic [2:0] i_state,
    output logic [2:0] o_device_state_field,
    output logic [1:0] o_reset_handshake_state
);
    // Handshake runs 01, then 10 at full speed or 11 at high speed
    always @(negedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_device_state_field <= 3'h0;
            o_reset_handshake_state <= 2'h0;
        end
        else
        begin
            o_device_state_field <= i_state;
            if (i_bus_reset)
                o_reset_handshake_state <= 2'h1;
            else if (o_reset_handshake_state == 2'h1)
                o_reset_handshake_state <= i_hs_capable ? 2'h3 : 2'h2;
        end
    end
endmodule
`default_nettype wire
